// ---- bench/flash_ctrl_tb.sv ----
// Self-checking bench for the FLASH clock divider, options and key unlock.
// Assumes flash_ctrl and its package are compiled first; clock is 10 MHz.
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_tb;
	import flash_ctrl_pkg::*;
	// Stimulus and observed ports
	logic          clk     = 1'b0;
	logic          reset_n = 1'b0;
	logic          psel    = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite  = 1'b0;
	logic [7:0]    paddr   = 8'h00;
	logic [31:0]   pwdata  = 32'h0;
	logic [31:0]   prdata;
	logic          pready;
	logic          perr;
	logic [7:0]    opts    = 8'hff;
	logic [63:0]   key     = 64'h0;
	cpu_write_type cw      = '0;
	logic          bc_done = 1'b0;
	logic          bc_ers  = 1'b0;
	logic          acc     = 1'b0;
	logic          acc_sec = 1'b0;
	logic          cmd, pe_en, fpulse, sec, redir, refused;
	// Bench state
	int            fails = 0, total_checks = 0, cycles = 0, cs_cnt = 0, ar_cnt = 0, n0, per;
	logic [31:0]   rd;
	logic [7:0]    dv;

	flash_ctrl u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(perr), .nonvolatile_options_byte(opts), .stored_backdoor_key(key),
		.cpu_write(cw), .blank_check_done(bc_done), .blank_check_erased(bc_ers),
		.cpu_access(acc), .cpu_access_secure(acc_sec), .command_start(cmd),
		.program_erase_enable(pe_en), .flash_clock_pulse(fpulse), .device_secure(sec),
		.redirection_disable(redir), .access_refused(refused));

	// Clock at 100 ns period
	always #50 clk = ~clk;

	// Pulse counters and hang guard
	always @(posedge clk) begin
		cycles++;
		if (cmd === 1'b1) cs_cnt++;
		if (refused === 1'b1) ar_cnt++;
		if (cycles == 20000) begin
			fails++;
			stop_test();
		end
	end

	// Expected pulse period and security decode
	function automatic int exp_period(input logic [7:0] d);
		return (d[PRESCALE_BIT] ? 8 : 1) * (int'(d[DIVISOR_MSB:0]) + 1);
	endfunction
	function automatic logic exp_secure(input logic [1:0] c);
		return c != SEC_UNSECURED;
	endfunction

	task automatic stop_test;
		$display("Checks %0d, errors %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error t=%0t byte got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error t=%0t flag got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic chkn(input int got, input int exp);
		total_checks++;
		if (got != exp) begin
			fails++;
			$display("Error t=%0t count got %0d exp %0d", $time, got, exp);
		end
	endtask

	// Reset with a given nonvolatile options byte
	task automatic rst(input logic [7:0] o);
		@(posedge clk) reset_n <= 1'b0;
		opts <= o;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// One APB transfer; holds until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk) psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One CPU write into the key window, then an idle cycle
	task automatic kw(input int i, input logic [7:0] d, input logic s, input logic g);
		@(posedge clk) cw <= '{1'b1, KEY_BASE + 16'(i), d, s, g};
		@(posedge clk) cw <= '0;
	endtask
	// Full key entry: set access bit, eight bytes in order, clear
	task automatic enter(input logic [63:0] k, input logic s, input logic g);
		apb(1'b1, ADDR_CONFIGURATION, 32'h20);
		apb(1'b0, ADDR_CONFIGURATION, 32'h0);
		chk8(rd[7:0], 8'h20);
		for (int i = 0; i < 8; i++) kw(i, k[63-8*i -: 8], s, g);
		apb(1'b1, ADDR_CONFIGURATION, 32'h0);
		repeat (4) @(posedge clk);
	endtask
	task automatic period(output int p);
		int n;
		n = 0;
		while (fpulse !== 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		p = 1;
		while (fpulse !== 1'b1 && p < 1000) begin
			@(posedge clk);
			p++;
		end
	endtask
	task automatic access(input logic s);
		@(posedge clk) acc <= 1'b1;
		acc_sec <= s;
		@(posedge clk) acc <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// Main sequence
	initial begin
		n0 = $urandom(71573);
		key = {$urandom, $urandom};
		rst(8'h83);
		chk1(sec, 1'b1);
		chk1(redir, 1'b0);
		chk1(pe_en, 1'b0);
		apb(1'b1, ADDR_OPTIONS, 32'h0);
		apb(1'b0, ADDR_OPTIONS, 32'h0);
		chk8(rd[7:0], 8'h83);
		apb(1'b0, ADDR_CONFIGURATION, 32'h0);
		chk8(rd[7:0], CONFIGURATION_RESET);
		apb(1'b0, ADDR_CLOCK_DIVIDER, 32'h0);
		chk8(rd[7:0], CLOCK_DIVIDER_RESET);
		apb(1'b0, 8'h10, 32'h0);
		chk8(rd[7:0], 8'h00);
		n0 = ar_cnt;
		access(1'b0);
		access(1'b1);
		chkn(ar_cnt - n0, 1);
		// Command step before the divider is loaded
		n0 = cs_cnt;
		kw(3, 8'($urandom), 1'b1, 1'b0);
		repeat (3) @(posedge clk);
		chkn(cs_cnt - n0, 0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk1(rd[ACCERR_BIT], 1'b1);
		// Divider: first write only, loaded flag
		dv = {2'b00, 6'($urandom_range(49, 63))};
		apb(1'b1, ADDR_CLOCK_DIVIDER, {24'h0, dv});
		apb(1'b1, ADDR_CLOCK_DIVIDER, $urandom | 32'h3f);
		chk1(perr, 1'b0);
		apb(1'b0, ADDR_CLOCK_DIVIDER, 32'h0);
		chk8(rd[7:0], dv | 8'h80);
		chk1(pe_en, 1'b1);
		period(per);
		chkn(per, exp_period(dv));
		n0 = cs_cnt;
		kw(7, 8'($urandom), 1'b1, 1'b0);
		repeat (3) @(posedge clk);
		chkn(cs_cnt - n0, 1);
		// Key entry: debug source, wrong key, then the right one
		enter(key, 1'b1, 1'b1);
		chk1(sec, 1'b1);
		enter(key ^ 64'h1, 1'b1, 1'b0);
		chk1(sec, 1'b1);
		n0 = cs_cnt;
		enter(key, 1'b1, 1'b0);
		chk1(sec, 1'b0);
		chkn(cs_cnt - n0, 0);
		n0 = ar_cnt;
		access(1'b0);
		chkn(ar_cnt - n0, 0);
		// Key disabled, redirection off, prescaled clock, blank check
		rst(8'h40);
		chk1(redir, 1'b1);
		dv = {2'b01, 6'($urandom_range(6, 7))};
		apb(1'b1, ADDR_CLOCK_DIVIDER, {24'h0, dv});
		period(per);
		chkn(per, exp_period(dv));
		enter(key, 1'b1, 1'b0);
		chk1(sec, 1'b1);
		@(posedge clk) bc_done <= 1'b1;
		bc_ers <= 1'b1;
		@(posedge clk) bc_done <= 1'b0;
		repeat (3) @(posedge clk);
		chk1(sec, 1'b0);
		// Every security code
		for (int c = 0; c < 4; c++) begin
			rst({6'h0, 2'(c)});
			chk1(sec, exp_secure(2'(c)));
		end
		stop_test();
	end
endmodule // flash_ctrl_tb
`default_nettype wire

// ---- design/flash_ctrl.sv ----
// FLASH clock divider, options and configuration registers with key unlock.
// Assumes an APB master on clk and a CPU write port from the memory map.
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl
	import flash_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	// APB slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// Nonvolatile contents presented by the array
	input  wire logic [7:0]    nonvolatile_options_byte,
	input  wire logic [63:0]   stored_backdoor_key,
	// CPU writes to FLASH space and sequencer events
	input  wire cpu_write_type cpu_write,
	input  wire logic          blank_check_done,
	input  wire logic          blank_check_erased,
	input  wire logic          cpu_access,
	input  wire logic          cpu_access_secure,
	// Outputs to the sequencer and system
	output logic               command_start,
	output logic               program_erase_enable,
	output logic               flash_clock_pulse,
	output logic               device_secure,
	output logic               redirection_disable,
	output logic               access_refused
);
	typedef enum logic [1:0] {
		KEY_IDLE    = 2'b00,
		KEY_CAPTURE = 2'b01,
		KEY_COMPARE = 2'b11
	} key_state_type;

	logic [7:0]    divider_q;
	logic [7:0]    options_q;
	logic          options_loaded_q;
	logic          key_access_q;
	logic          access_error_q;
	logic          blank_q;
	logic [63:0]   key_capture_q;
	logic [2:0]    key_index_q;
	logic          key_order_ok_q;
	logic          key_secure_ok_q;
	key_state_type key_state_q;
	logic [2:0]    prescale_q;
	logic [5:0]    divide_q;
	logic          flash_clock_pulse_q;
	logic          command_start_q;
	logic          access_refused_q;
	logic          apb_write;
	logic          apb_write_done;
	logic          key_window_hit;
	logic          prescale_tick;
	logic          op_attempt;

	// Bus access decode; the slave answers in the first access cycle
	assign pready    = 1'b1;
	assign pslverr   = 1'b0;
	assign apb_write = psel & penable & pwrite;
	assign apb_write_done = apb_write;

	// Read mux, registered data on completion is not required by APB
	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			ADDR_CLOCK_DIVIDER: prdata = {24'h00_0000, divider_q};
			ADDR_OPTIONS:       prdata = {24'h00_0000, options_q};
			ADDR_CONFIGURATION: prdata = {26'h000_0000, key_access_q, 5'h00};
			ADDR_STATUS:        prdata = {27'h000_0000, access_error_q, 1'b0, blank_q, 2'h0};
			default:            prdata = 32'h0000_0000;
		endcase
	end

	// Divider register: seven bits written once, load flag set by that write
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			divider_q <= CLOCK_DIVIDER_RESET;
		end else if (apb_write_done && paddr == ADDR_CLOCK_DIVIDER && !divider_q[DIVLOAD_BIT]) begin
			divider_q <= {1'b1, pwdata[6:0]};
		end
	end

	assign program_erase_enable = divider_q[DIVLOAD_BIT];

	// Prescaler of eight, bypassed when the prescale bit is clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prescale_q <= 3'h0;
		end else begin
			prescale_q <= prescale_q + 3'h1;
		end
	end
	assign prescale_tick = divider_q[PRESCALE_BIT] ? (prescale_q == PRESCALE_LAST) : 1'b1;

	// Divide by divisor plus one; one pulse per internal FLASH clock period
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			divide_q            <= 6'h00;
			flash_clock_pulse_q <= 1'b0;
		end else begin
			flash_clock_pulse_q <= 1'b0;
			if (!divider_q[DIVLOAD_BIT]) begin
				divide_q <= 6'h00;
			end else if (prescale_tick) begin
				if (divide_q == divider_q[DIVISOR_MSB:0]) begin
					divide_q            <= 6'h00;
					flash_clock_pulse_q <= 1'b1;
				end else begin
					divide_q <= divide_q + 6'h01;
				end
			end
		end
	end
	assign flash_clock_pulse = flash_clock_pulse_q;

	// Options load after reset release, then only the unlock paths change it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			options_q        <= 8'hff;
			options_loaded_q <= 1'b0;
		end else if (!options_loaded_q) begin
			options_q        <= nonvolatile_options_byte;
			options_loaded_q <= 1'b1;
		end else if ((key_state_q == KEY_COMPARE && options_q[BACKDOOR_KEY_ENABLE_BIT] && key_order_ok_q
				&& key_secure_ok_q && key_capture_q == stored_backdoor_key)
				|| (blank_check_done && blank_check_erased)) begin
			options_q[1:0] <= SEC_UNSECURED;
		end
	end

	assign device_secure       = !options_loaded_q || options_q[1:0] != SEC_UNSECURED;
	assign redirection_disable = options_q[NORED_BIT];

	// Configuration register holds the key access bit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			key_access_q <= 1'b0;
		end else if (apb_write_done && paddr == ADDR_CONFIGURATION) begin
			key_access_q <= pwdata[KEY_ACCESS_BIT_BIT];
		end
	end

	assign key_window_hit = cpu_write.valid && cpu_write.addr[15:3] == KEY_BASE[15:3];

	// Key entry: capture in order while key access is set, compare on its clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			key_state_q     <= KEY_IDLE;
			key_capture_q   <= 64'h0;
			key_index_q     <= 3'h0;
			key_order_ok_q  <= 1'b1;
			key_secure_ok_q <= 1'b1;
		end else begin
			case (key_state_q)
				KEY_IDLE: begin
					key_index_q     <= 3'h0;
					key_order_ok_q  <= 1'b1;
					key_secure_ok_q <= 1'b1;
					if (key_access_q) begin
						key_state_q <= KEY_CAPTURE;
					end
				end
				KEY_CAPTURE: begin
					if (key_window_hit) begin
						key_capture_q[8*(7-cpu_write.addr[2:0]) +: 8] <= cpu_write.data;
						key_index_q <= key_index_q + 3'h1;
						if (cpu_write.addr[2:0] != key_index_q) begin
							key_order_ok_q <= 1'b0;
						end
						if (!cpu_write.from_secure || cpu_write.from_debug) begin
							key_secure_ok_q <= 1'b0;
						end
					end
					if (!key_access_q) begin
						key_state_q <= KEY_COMPARE;
					end
				end
				KEY_COMPARE: begin
					key_state_q <= KEY_IDLE;
				end
				default: key_state_q <= KEY_IDLE;
			endcase
		end
	end

	assign op_attempt = key_window_hit && !key_access_q;

	// Command start and access error on key-window writes while key access is clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			command_start_q <= 1'b0;
			access_error_q  <= 1'b0;
		end else begin
			command_start_q <= op_attempt && divider_q[DIVLOAD_BIT];
			if (op_attempt && !divider_q[DIVLOAD_BIT]) begin
				access_error_q <= 1'b1;
			end else if (apb_write_done && paddr == ADDR_STATUS && pwdata[ACCERR_BIT]) begin
				access_error_q <= 1'b0;
			end
		end
	end
	assign command_start = command_start_q;

	// Blank result flag
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			blank_q <= 1'b0;
		end else if (blank_check_done) begin
			blank_q <= blank_check_erased;
		end
	end

	// Refuse RAM and FLASH accesses from unsecured sources while secure
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			access_refused_q <= 1'b0;
		end else begin
			access_refused_q <= cpu_access && !cpu_access_secure && device_secure;
		end
	end
	assign access_refused = access_refused_q;

	// Assertions
	AST_DIV_ONCE: assert property (@(posedge clk) disable iff (!reset_n)
		$past(divider_q[DIVLOAD_BIT]) |-> $stable(divider_q))
		else $error("divider changed after first write");
	AST_LOAD_SET: assert property (@(posedge clk) disable iff (!reset_n)
		apb_write && paddr == ADDR_CLOCK_DIVIDER |=> divider_q[DIVLOAD_BIT])
		else $error("load flag not set by divider write");
	AST_NO_CMD_UNLOADED: assert property (@(posedge clk) disable iff (!reset_n)
		command_start |-> divider_q[DIVLOAD_BIT])
		else $error("command started before divider load");
	AST_ACCERR: assert property (@(posedge clk) disable iff (!reset_n)
		op_attempt && !divider_q[DIVLOAD_BIT] |=> access_error_q && !command_start)
		else $error("access error missing");
	AST_CMD_START: assert property (@(posedge clk) disable iff (!reset_n)
		op_attempt && divider_q[DIVLOAD_BIT] |=> command_start)
		else $error("command step missing");
	AST_NO_CMD_KEY_ACCESS_BIT: assert property (@(posedge clk) disable iff (!reset_n)
		key_window_hit && key_access_q |=> !command_start)
		else $error("key write started a command");
	AST_SECURE_DECODE: assert property (@(posedge clk) disable iff (!reset_n)
		options_loaded_q |-> device_secure == (options_q[1:0] != 2'h2))
		else $error("security decode wrong");
	AST_BACKDOOR_KEY_ENABLE_OFF: assert property (@(posedge clk) disable iff (!reset_n)
		options_loaded_q && !options_q[BACKDOOR_KEY_ENABLE_BIT] && device_secure && !blank_check_done
		|=> device_secure)
		else $error("unlocked with key disabled");
	AST_PULSE_GAP: assert property (@(posedge clk) disable iff (!reset_n)
		flash_clock_pulse && divider_q[PRESCALE_BIT] |-> $past(prescale_q) == PRESCALE_LAST)
		else $error("prescaled pulse off the prescaler boundary");
	AST_PULSE_SPACING: assert property (@(posedge clk) disable iff (!reset_n)
		flash_clock_pulse && divider_q[DIVISOR_MSB:0] != 6'h00 |=> !flash_clock_pulse)
		else $error("pulses closer than divisor allows");
	AST_REFUSE: assert property (@(posedge clk) disable iff (!reset_n)
		cpu_access && !cpu_access_secure && device_secure |=> access_refused)
		else $error("unsecured access not refused");
endmodule // flash_ctrl
`default_nettype wire

// ---- design/flash_ctrl_pkg.sv ----
// Constants, register map and carrier types for the FLASH control registers.
// Assumes a 10 MHz bus clock and an APB master with 32-bit data.
// How it works
// - Divider bits 6:0 take only the first write after reset; bit 7 read-only.
// - Divisor-loaded flag clears on reset, sets on first divider write.
// - Program and erase are blocked while the divisor-loaded flag is 0.
// - Prescale bit 6 selects bus clock divided by 8 as divider input.
// - Internal FLASH clock is the selected input divided by divisor plus one.
// - Each timing pulse is one internal FLASH clock; operations count whole pulses.
// - Options byte is copied from nonvolatile storage at reset only.
// - With key enable 0 the key comparison never lifts security.
// - Key values only count from secured code, never from debug writes.
// - Matching eight-byte key written in order lifts security until reset.
// - Redirection-disable bit 6 turns vector redirection off when 1.
// - Only security code 1:0 is unsecured; other codes are secure.
// - While secure, accesses from unsecured sources to RAM and FLASH are refused.
// - Security code becomes 1:0 after key match or all-blank check.
// - Key-access 0 makes key-location writes the first step of a command.
// - Key-access 1 captures key-location writes as comparison values.
// - Set key-access, write eight bytes in order, clear it; clear triggers compare.
// - Operation attempted before divider write is ignored and sets access error.
package flash_ctrl_pkg;
	// APB byte addresses
	localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'h00;
	localparam logic [7:0] ADDR_OPTIONS       = 8'h04;
	localparam logic [7:0] ADDR_CONFIGURATION = 8'h08;
	localparam logic [7:0] ADDR_STATUS        = 8'h0c;
	// Divider fields
	localparam int DIVLOAD_BIT  = 7;
	localparam int PRESCALE_BIT = 6;
	localparam int DIVISOR_MSB  = 5;
	localparam logic [2:0] PRESCALE_LAST = 3'h7; // Divide by 8
	// Options fields
	localparam int BACKDOOR_KEY_ENABLE_BIT  = 7;
	localparam int NORED_BIT  = 6;
	localparam logic [1:0] SEC_UNSECURED = 2'h2;
	// Configuration field
	localparam int KEY_ACCESS_BIT_BIT = 5;
	// Status fields
	localparam int ACCERR_BIT = 4;
	localparam int BLANK_BIT  = 2;
	// Key window in the CPU map
	localparam logic [15:0] KEY_BASE = 16'hffb0;
	localparam logic [2:0]  KEY_LAST = 3'h7;
	// Timing: FLASH clock limits
	localparam int INTERNAL_FLASH_CLOCK_MIN_KHZ = 150;
	localparam int INTERNAL_FLASH_CLOCK_MAX_KHZ = 200;
	localparam int BUS_KHZ      = 10000;
	// Reset values
	localparam logic [7:0] CLOCK_DIVIDER_RESET = 8'h00;
	localparam logic [7:0] CONFIGURATION_RESET = 8'h00;

	// A CPU-side write to the FLASH array space
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [7:0]  data;
		logic        from_secure;
		logic        from_debug;
	} cpu_write_type;
endpackage : flash_ctrl_pkg
